// File: design/generic_holding_config_regs.v
// Generic configuration holding registers of the flow transmitter.
`timescale 1ns/100ps
module generic_holding_config_regs (
   input  wire        mclk,
   input  wire        rst_b,
   input  wire        porRst_b,
   input  wire        ce,
   input  wire        regWr,
   input  wire        regRd,
   input  wire [15:0] regAddr,
   input  wire [31:0] regWdata,
   output reg  [31:0] regRdata,
   output reg         regAck,
   output reg         regErr,
   output reg  [3:0]  pollId,
   output reg         loopEnable,
   output reg         loopFixed4mA,
   output reg  [3:0]  preambleCount,
   output reg  [1:0]  timeSyncPolicy,
   output reg  [31:0] statsCycleBase,
   output wire        logRun,
   output reg  [9:0]  logPeriod,
   output reg         phaseFilterEn,
   output reg  [6:0]  precisionSource,
   output reg         restartReq,
   output wire [23:0] nvClearAddr,
   output wire        nvClearWe,
   output wire        nvClearBusy
);
`include "holding_regs_defs.vh"

   reg  [31:0] failClear_reg;
   reg  [31:0] pollId_reg;
   reg  [31:0] loopEnable_reg;
   reg  [31:0] preamble_reg;
   reg  [31:0] timeSync_reg;
   reg  [31:0] statsBase_reg;
   reg  [31:0] logPeriod_reg;
   reg  [31:0] precision_reg;
   reg  [31:0] restart_reg;
   reg         restartArmed_reg;
   reg         clearStart_reg;
   reg         logSet_reg;
   reg         logValue_reg;
   reg  [31:0] readValue;
   reg         mapped;
   reg         inRange;

   // Range check shared by the write path; unknown offsets are never in range.
   function valueOk;
      input [15:0] addr;
      input [31:0] val;
      begin
         case (addr)
            `OFS_FAILURE_COUNTER_CLEAR:   valueOk = (val <= `CLEAR_START_VALUE);
            `OFS_POLL_IDENTIFIER:         valueOk = (val <= `POLL_ID_MAX);
            `OFS_LOOP_CURRENT_ENABLE:     valueOk = (val <= 32'h00000001);
            `OFS_PREAMBLE_COUNT:          valueOk = (val >= `PREAMBLE_MIN) &&
                                                    (val <= `PREAMBLE_MAX);
            `OFS_TIME_SYNC_POLICY:        valueOk = (val <= `SYNC_ALL);
            `OFS_STATS_CYCLE_BASE:        valueOk = (val != 32'h00000000);
            `OFS_LOG_RUN_CONTROL:         valueOk = (val <= 32'h00000001);
            `OFS_LOG_PERIOD_SECONDS:      valueOk = (val >= `LOG_PERIOD_MIN) &&
                                                    (val <= `LOG_PERIOD_MAX);
            `OFS_PRECISION_OUTPUT_SELECT: valueOk = (val[31:8] == 24'h000000) &&
               (val[`PREC_SOURCE_MSB:`PREC_SOURCE_LSB] <= `PREC_SOURCE_MAX);
            `OFS_ROLLING_RESTART_TRIGGER: valueOk = 1'b1;
            default:                      valueOk = 1'b0;
         endcase
      end
   endfunction

   always @* begin
      mapped    = 1'b1;
      readValue = 32'h00000000;
      case (regAddr)
         `OFS_FAILURE_COUNTER_CLEAR:   readValue = failClear_reg;
         `OFS_POLL_IDENTIFIER:         readValue = pollId_reg;
         `OFS_LOOP_CURRENT_ENABLE:     readValue = loopEnable_reg;
         `OFS_PREAMBLE_COUNT:          readValue = preamble_reg;
         `OFS_TIME_SYNC_POLICY:        readValue = timeSync_reg;
         `OFS_STATS_CYCLE_BASE:        readValue = statsBase_reg;
         `OFS_LOG_RUN_CONTROL:         readValue = {31'h00000000, logRun};
         `OFS_LOG_PERIOD_SECONDS:      readValue = logPeriod_reg;
         `OFS_PRECISION_OUTPUT_SELECT: readValue = precision_reg;
         `OFS_ROLLING_RESTART_TRIGGER: readValue = restart_reg;
         default:                      mapped    = 1'b0;
      endcase
      inRange = valueOk(regAddr, regWdata);
   end

   // Register writes. A refused write touches nothing and only raises regErr.
   always @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         failClear_reg    <= `RST_FAILURE_COUNTER_CLEAR;
         pollId_reg       <= `RST_POLL_IDENTIFIER;
         loopEnable_reg   <= `RST_LOOP_CURRENT_ENABLE;
         preamble_reg     <= `RST_PREAMBLE_COUNT;
         timeSync_reg     <= `RST_TIME_SYNC_POLICY;
         statsBase_reg    <= `RST_STATS_CYCLE_BASE;
         logPeriod_reg    <= `RST_LOG_PERIOD_SECONDS;
         precision_reg    <= `RST_PRECISION_OUTPUT_SELECT;
         restart_reg      <= `RST_ROLLING_RESTART_TRIGGER;
         restartArmed_reg <= 1'b0;
         restartReq       <= 1'b0;
         clearStart_reg   <= 1'b0;
         logSet_reg       <= 1'b0;
         logValue_reg     <= 1'b0;
      end else if (ce) begin
         restartReq     <= 1'b0;
         clearStart_reg <= 1'b0;
         logSet_reg     <= 1'b0;
         if (regWr && inRange) begin
            case (regAddr)
               `OFS_FAILURE_COUNTER_CLEAR: begin
                  failClear_reg  <= regWdata;
                  clearStart_reg <= (regWdata == `CLEAR_START_VALUE);
               end
               `OFS_POLL_IDENTIFIER:         pollId_reg     <= regWdata;
               `OFS_LOOP_CURRENT_ENABLE:     loopEnable_reg <= regWdata;
               `OFS_PREAMBLE_COUNT:          preamble_reg   <= regWdata;
               `OFS_TIME_SYNC_POLICY:        timeSync_reg   <= regWdata;
               `OFS_STATS_CYCLE_BASE:        statsBase_reg  <= regWdata;
               `OFS_LOG_RUN_CONTROL: begin
                  logSet_reg   <= 1'b1;
                  logValue_reg <= regWdata[0];
               end
               `OFS_LOG_PERIOD_SECONDS:      logPeriod_reg  <= regWdata;
               `OFS_PRECISION_OUTPUT_SELECT: precision_reg  <= regWdata;
               `OFS_ROLLING_RESTART_TRIGGER: begin
                  restart_reg <= regWdata;
                  // Any other value arms; writing the magic value while armed fires.
                  if (regWdata != `RESTART_MAGIC) begin
                     restartArmed_reg <= 1'b1;
                  end else if (restartArmed_reg) begin
                     restartArmed_reg <= 1'b0;
                     restartReq       <= 1'b1;
                  end
               end
               default: begin
               end
            endcase
         end
      end
   end

   // Bus answer: one cycle after the strobe, data registered, error on refusal.
   always @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         regRdata <= 32'h00000000;
         regAck   <= 1'b0;
         regErr   <= 1'b0;
      end else if (ce) begin
         regAck   <= regWr | regRd;
         regErr   <= (regRd && !mapped) || (regWr && !inRange);
         if (regRd && mapped) begin
            regRdata <= readValue;
         end else begin
            regRdata <= 32'h00000000;
         end
      end
   end

   // Function outputs, registered from the stored values.
   always @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         pollId          <= 4'h0;
         loopEnable      <= 1'b0;
         loopFixed4mA    <= 1'b1;
         preambleCount   <= 4'h5;
         timeSyncPolicy  <= 2'h0;
         statsCycleBase  <= `RST_STATS_CYCLE_BASE;
         logPeriod       <= 10'h001;
         phaseFilterEn   <= 1'b0;
         precisionSource <= 7'h00;
      end else if (ce) begin
         pollId          <= pollId_reg[3:0];
         // The poll identifier is deliberately left out of the loop decision.
         loopEnable      <= loopEnable_reg[0];
         loopFixed4mA    <= ~loopEnable_reg[0];
         preambleCount   <= preamble_reg[3:0];
         timeSyncPolicy  <= timeSync_reg[1:0];
         statsCycleBase  <= statsBase_reg;
         logPeriod       <= logPeriod_reg[9:0];
         phaseFilterEn   <= precision_reg[`PREC_FILTER_BIT];
         precisionSource <= precision_reg[`PREC_SOURCE_MSB:`PREC_SOURCE_LSB];
      end
   end

   retained_log_state u_logState (
      .mclk       (mclk),
      .porRst_b   (porRst_b),
      .ce         (ce),
      .setStrobe  (logSet_reg),
      .setValue   (logValue_reg),
      .logRun_reg (logRun)
   );

   nv_counter_clear #(
      .FIRST_ADDR (`NV_CLEAR_FIRST),
      .LAST_ADDR  (`NV_CLEAR_LAST)
   ) u_clear (
      .mclk       (mclk),
      .rst_b      (rst_b),
      .ce         (ce),
      .start      (clearStart_reg),
      .nvAddr_reg (nvClearAddr),
      .nvWe_reg   (nvClearWe),
      .busy_reg   (nvClearBusy)
   );
endmodule // generic_holding_config_regs

// File: design/holding_regs_defs.vh
// Offsets, field positions, limits and reset values of the generic holding registers.
`ifndef HOLDING_REGS_DEFS_VH
`define HOLDING_REGS_DEFS_VH

`define OFS_FAILURE_COUNTER_CLEAR   16'h600a
`define OFS_POLL_IDENTIFIER         16'h60a0
`define OFS_LOOP_CURRENT_ENABLE     16'h60a2
`define OFS_PREAMBLE_COUNT          16'h60a4
`define OFS_TIME_SYNC_POLICY        16'h60ae
`define OFS_STATS_CYCLE_BASE        16'h60d0
`define OFS_LOG_RUN_CONTROL         16'h60d2
`define OFS_LOG_PERIOD_SECONDS      16'h60d4
`define OFS_PRECISION_OUTPUT_SELECT 16'h60d6
`define OFS_ROLLING_RESTART_TRIGGER 16'h60e6

`define RST_FAILURE_COUNTER_CLEAR   32'h00000000
`define RST_POLL_IDENTIFIER         32'h00000000
`define RST_LOOP_CURRENT_ENABLE     32'h00000000
`define RST_PREAMBLE_COUNT          32'h00000005
`define RST_TIME_SYNC_POLICY        32'h00000000
`define RST_STATS_CYCLE_BASE        32'h00000001
`define RST_LOG_RUN_CONTROL         1'b0
`define RST_LOG_PERIOD_SECONDS      32'h00000001
`define RST_PRECISION_OUTPUT_SELECT 32'h00000000
`define RST_ROLLING_RESTART_TRIGGER 32'h0000dead

`define CLEAR_START_VALUE           32'h00000001
`define POLL_ID_MAX                 32'h0000000f
`define PREAMBLE_MIN                32'h00000005
`define PREAMBLE_MAX                32'h0000000f
`define SYNC_NONE                   32'h00000000
`define SYNC_TRUSTED                32'h00000001
`define SYNC_ALL                    32'h00000002
`define LOG_PERIOD_MIN              32'h00000001
`define LOG_PERIOD_MAX              32'h00000258
`define PREC_FILTER_BIT             0
`define PREC_SOURCE_LSB             1
`define PREC_SOURCE_MSB             7
`define PREC_SOURCE_MAX             7'h0b
`define RESTART_MAGIC               32'h0000dead
`define RESTART_ARM_VALUE           32'h00000000

`define NV_CLEAR_FIRST              24'h13fe00
`define NV_CLEAR_LAST               24'h13ff00

`endif

// File: design/retained_log_state.v
// Logging run state held on the power-on reset only, so system resets leave it intact.
`timescale 1ns/100ps
module retained_log_state (
   input  wire mclk,
   input  wire porRst_b,
   input  wire ce,
   input  wire setStrobe,
   input  wire setValue,
   output reg  logRun_reg
);
`include "holding_regs_defs.vh"

   // The system reset is deliberately not wired here; only power-on clears the state.
   always @(posedge mclk or negedge porRst_b) begin
      if (!porRst_b) begin
         logRun_reg <= `RST_LOG_RUN_CONTROL;
      end else if (ce && setStrobe) begin
         logRun_reg <= setValue;
      end
   end
endmodule // retained_log_state

// File: design/nv_counter_clear.v
// Sequencer that zeroes every word of the failure-counter area in non-volatile memory.
`timescale 1ns/100ps
`include "holding_regs_defs.vh"
module nv_counter_clear #(
   parameter [23:0] FIRST_ADDR = `NV_CLEAR_FIRST,
   parameter [23:0] LAST_ADDR  = `NV_CLEAR_LAST
) (
   input  wire        mclk,
   input  wire        rst_b,
   input  wire        ce,
   input  wire        start,
   output reg  [23:0] nvAddr_reg,
   output reg         nvWe_reg,
   output reg         busy_reg
);

   // A start while busy restarts nothing; the walk already covers the whole area.
   always @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         nvAddr_reg <= 24'h000000;
         nvWe_reg   <= 1'b0;
         busy_reg   <= 1'b0;
      end else if (ce) begin
         if (!busy_reg) begin
            if (start) begin
               nvAddr_reg <= FIRST_ADDR;
               nvWe_reg   <= 1'b1;
               busy_reg   <= 1'b1;
            end else begin
               nvWe_reg   <= 1'b0;
            end
         end else if (nvAddr_reg == LAST_ADDR) begin
            nvWe_reg <= 1'b0;
            busy_reg <= 1'b0;
         end else begin
            nvAddr_reg <= nvAddr_reg + 24'h000001;
         end
      end
   end
endmodule // nv_counter_clear

// File: tb/ghc_regs_chk.sv
// Checker that watches the ports of the generic holding register bank.
`timescale 1ns/100ps
module ghc_regs_chk (
   input wire        mclk,
   input wire        rst_b,
   input wire        ce,
   input wire        regWr,
   input wire        regRd,
   input wire [15:0] regAddr,
   input wire [31:0] regWdata,
   input wire        regAck,
   input wire        regErr,
   input wire [3:0]  pollId,
   input wire        loopEnable,
   input wire        loopFixed4mA,
   input wire [3:0]  preambleCount,
   input wire [1:0]  timeSyncPolicy,
   input wire        logRun,
   input wire [9:0]  logPeriod,
   input wire [6:0]  precisionSource,
   input wire        restartReq,
   input wire [23:0] nvClearAddr,
   input wire        nvClearBusy
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_b);
   property p_ack; ce && (regWr || regRd) |=> regAck; endproperty
   a_ack: assert property (p_ack) else $error("strobe without acknowledge");
   property p_loop;
      ce && regWr && regAddr == 16'h60a2 && regWdata <= 32'h1
      |=> ##1 loopFixed4mA == !$past(regWdata[0], 2) && loopFixed4mA == !loopEnable;
   endproperty
   a_loop: assert property (p_loop) else $error("loop hold disagrees with enable");
   property p_poll;
      ce && regWr && regAddr == 16'h60a0 && regWdata < 32'h10
      |=> !regErr ##1 pollId == $past(regWdata[3:0], 2);
   endproperty
   a_poll: assert property (p_poll) else $error("poll identifier not taken");
   property p_preErr; ce && regWr && regAddr == 16'h60a4 && regWdata < 32'h5 |=> regErr;
   endproperty
   a_preErr: assert property (p_preErr) else $error("short preamble accepted");
   property p_log; ce && regWr && regAddr == 16'h60d2 && regWdata == 32'h1 |=> ##1 logRun;
   endproperty
   a_log: assert property (p_log) else $error("logging did not start");
   property p_restart;
      restartReq |-> $past(regWr) && $past(regWdata) == 32'hdead && $past(regAddr) == 16'h60e6;
   endproperty
   a_restart: assert property (p_restart) else $error("restart without trigger write");
   property p_nv; $rose(nvClearBusy) |-> nvClearAddr == 24'h13fe00; endproperty
   a_nv: assert property (p_nv) else $error("clear starts at wrong address");
   property p_pre; preambleCount >= 4'h5; endproperty
   a_pre: assert property (p_pre) else $error("preamble count too small");
   property p_per; logPeriod != 10'h000 && logPeriod <= 10'h258; endproperty
   a_per: assert property (p_per) else $error("log period out of range");
   property p_prec; precisionSource <= 7'h0b; endproperty
   a_prec: assert property (p_prec) else $error("unknown precision source");
   property p_sync; timeSyncPolicy != 2'h3; endproperty
   a_sync: assert property (p_sync) else $error("reserved time sync code");
endmodule // ghc_regs_chk

// File: tb/reg_master_model.sv
// Holding-register master that issues one strobed access at a time.
`timescale 1ns/100ps
module reg_master_model (
   input  wire        mclk,
   input  wire        regAck,
   input  wire        regErr,
   input  wire [31:0] regRdata,
   output logic       regWr,
   output logic       regRd,
   output logic [15:0] regAddr,
   output logic [31:0] regWdata
);
   initial begin
      regWr = 1'b0;
      regRd = 1'b0;
      regAddr = 16'h0000;
      regWdata = 32'h00000000;
   end
   // Address and data are inverted after use and the strobes dropped, so a stale value can never pass for a fresh one.
   task automatic acc(input logic wr, input logic [15:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic e);
      int n;
      @(negedge mclk);
      regAddr = a;
      regWdata = d;
      regWr = wr;
      regRd = !wr;
      @(negedge mclk);
      regWr = 1'b0;
      regRd = 1'b0;
      regAddr = ~a;
      regWdata = ~d;
      n = 0;
      while (regAck !== 1'b1 && n < 4) begin
         @(negedge mclk);
         n++;
      end
      q = regRdata;
      e = (n < 4) ? regErr : 1'bx;
   endtask
endmodule // reg_master_model

// File: tb/generic_holding_config_regs_tb.sv
// Self-checking bench for the generic holding register bank.
`timescale 1ns/100ps
module generic_holding_config_regs_tb;
   logic mclk = 1'b0, rst_b = 1'b0, porRst_b = 1'b0, ce = 1'b1;
   wire regWr, regRd, regAck, regErr, loopEnable, loopFixed4mA, logRun, phaseFilterEn;
   wire restartReq, nvClearWe, nvClearBusy;
   wire [15:0] regAddr;
   wire [31:0] regWdata, regRdata, statsCycleBase;
   wire [3:0] pollId, preambleCount;
   wire [1:0] timeSyncPolicy;
   wire [9:0] logPeriod;
   wire [6:0] precisionSource;
   wire [23:0] nvClearAddr;
   int num_errors = 0, samples_checked = 0, cyc = 0, rsCnt = 0, weCnt = 0;
   logic [23:0] firstA, lastA;
   always #5 mclk = ~mclk;
   generic_holding_config_regs DUT (.mclk(mclk), .rst_b(rst_b), .porRst_b(porRst_b),
      .ce(ce), .regWr(regWr), .regRd(regRd), .regAddr(regAddr), .regWdata(regWdata),
      .regRdata(regRdata), .regAck(regAck), .regErr(regErr), .pollId(pollId),
      .loopEnable(loopEnable), .loopFixed4mA(loopFixed4mA), .preambleCount(preambleCount),
      .timeSyncPolicy(timeSyncPolicy), .statsCycleBase(statsCycleBase), .logRun(logRun),
      .logPeriod(logPeriod), .phaseFilterEn(phaseFilterEn), .precisionSource(precisionSource),
      .restartReq(restartReq), .nvClearAddr(nvClearAddr), .nvClearWe(nvClearWe),
      .nvClearBusy(nvClearBusy));
   reg_master_model PM (.mclk(mclk), .regAck(regAck), .regErr(regErr), .regRdata(regRdata),
      .regWr(regWr), .regRd(regRd), .regAddr(regAddr), .regWdata(regWdata));
   // Monitors sample at the falling edge, away from the edge that launches each pulse.
   always @(negedge mclk) begin
      cyc++;
      if (restartReq === 1'b1) rsCnt++;
      if (nvClearWe === 1'b1) begin
         if (weCnt == 0) firstA = nvClearAddr;
         weCnt++;
         lastA = nvClearAddr;
      end
      if (cyc == 20000) begin
         num_errors++;
         print_verdict();
      end
   end
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", samples_checked, num_errors);
      if (num_errors == 0 && samples_checked > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         num_errors++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [15:0] a, input logic [31:0] d, input logic ee);
      logic [31:0] q;
      logic e;
      PM.acc(1'b1, a, d, q, e);
      chk({31'h0, e}, {31'h0, ee});
   endtask
   task automatic rd(input logic [15:0] a, input logic [31:0] x, input logic ee);
      logic [31:0] q;
      logic e;
      PM.acc(1'b0, a, 32'h0, q, e);
      chk(q, x);
      chk({31'h0, e}, {31'h0, ee});
   endtask
   task automatic t_defaults();
      logic [15:0] ad[10] = '{16'h600a, 16'h60a0, 16'h60a2, 16'h60a4, 16'h60ae,
                              16'h60d0, 16'h60d2, 16'h60d4, 16'h60d6, 16'h60e6};
      logic [31:0] ex[10] = '{32'h0, 32'h0, 32'h0, 32'h5, 32'h0, 32'h1, 32'h0, 32'h1,
                              32'h0, 32'hdead};
      for (int i = 0; i < 10; i++) rd(ad[i], ex[i], 1'b0);
      rd(16'h6000, 32'h0, 1'b1);
      $display("defaults done");
   endtask
   task automatic t_poll_loop();
      wr(16'h60a0, 32'hf, 1'b0);
      wr(16'h60a0, 32'h10, 1'b1);
      rd(16'h60a0, 32'hf, 1'b0);
      wr(16'h60a2, 32'h1, 1'b0);
      wr(16'h60a0, 32'h3, 1'b0);
      repeat (2) @(negedge mclk);
      chk({31'h0, loopFixed4mA}, 32'h0);
      chk({31'h0, loopEnable}, 32'h1);
      chk({28'h0, pollId}, 32'h3);
      wr(16'h60a2, 32'h2, 1'b1);
      wr(16'h60a2, 32'h0, 1'b0);
      repeat (2) @(negedge mclk);
      chk({31'h0, loopFixed4mA}, 32'h1);
      chk({31'h0, loopEnable}, 32'h0);
      $display("poll and loop done");
   endtask
   task automatic t_fields();
      wr(16'h60a4, 32'h4, 1'b1);
      wr(16'h60a4, 32'hf, 1'b0);
      wr(16'h60a4, 32'h10, 1'b1);
      for (int i = 0; i < 4; i++) wr(16'h60ae, i, i == 3);
      rd(16'h60ae, 32'h2, 1'b0);
      wr(16'h60d4, 32'h0, 1'b1);
      wr(16'h60d4, 32'h259, 1'b1);
      wr(16'h60d4, 32'h258, 1'b0);
      for (int i = 0; i < 13; i++) wr(16'h60d6, {i[30:0], 1'b1}, i == 12);
      wr(16'h60d6, 32'h100, 1'b1);
      rd(16'h60d6, 32'h17, 1'b0);
      wr(16'h60d0, 32'h0, 1'b1);
      wr(16'h60d0, 32'h7, 1'b0);
      repeat (2) @(negedge mclk);
      chk({22'h0, logPeriod}, 32'h258);
      chk({25'h0, precisionSource}, 32'hb);
      chk({31'h0, phaseFilterEn}, 32'h1);
      chk({28'h0, preambleCount}, 32'hf);
      chk({30'h0, timeSyncPolicy}, 32'h2);
      chk(statsCycleBase, 32'h7);
      $display("fields done");
   endtask
   task automatic t_log_restart();
      int c0;
      wr(16'h60d2, 32'h1, 1'b0);
      @(negedge mclk);
      chk({31'h0, logRun}, 32'h1);
      rst_b = 1'b0;
      repeat (2) @(negedge mclk);
      rst_b = 1'b1;
      chk({31'h0, logRun}, 32'h1);
      wr(16'h60d2, 32'h0, 1'b0);
      @(negedge mclk);
      chk({31'h0, logRun}, 32'h0);
      c0 = rsCnt;
      wr(16'h60e6, 32'hdead, 1'b0);
      wr(16'h60e6, 32'h0, 1'b0);
      wr(16'h60e6, 32'hdead, 1'b0);
      // The pulse is counted at the falling edge after it rises; let that edge pass.
      @(negedge mclk);
      chk(rsCnt - c0, 32'h1);
      $display("log and restart done");
   endtask
   task automatic t_nv_clear();
      int n = 0;
      wr(16'h600a, 32'h1, 1'b0);
      repeat (3) @(negedge mclk);
      while (nvClearBusy === 1'b1 && n < 400) begin
         @(negedge mclk);
         n++;
      end
      chk(weCnt, 32'd257);
      chk({8'h0, firstA}, 32'h13fe00);
      chk({8'h0, lastA}, 32'h13ff00);
      $display("counter clear done");
   endtask
   initial begin
      repeat (12) @(negedge mclk);
      rst_b = 1'b1;
      porRst_b = 1'b1;
      t_defaults();
      t_poll_loop();
      t_fields();
      t_log_restart();
      t_nv_clear();
      print_verdict();
   end
endmodule // generic_holding_config_regs_tb
bind generic_holding_config_regs ghc_regs_chk CHK (.mclk(mclk), .rst_b(rst_b), .ce(ce),
   .regWr(regWr), .regRd(regRd), .regAddr(regAddr), .regWdata(regWdata), .regAck(regAck),
   .regErr(regErr), .pollId(pollId), .loopEnable(loopEnable), .loopFixed4mA(loopFixed4mA),
   .preambleCount(preambleCount), .timeSyncPolicy(timeSyncPolicy), .logRun(logRun),
   .logPeriod(logPeriod), .precisionSource(precisionSource), .restartReq(restartReq),
   .nvClearAddr(nvClearAddr), .nvClearBusy(nvClearBusy));
